// ### rtl/icwr_pkg.sv
// Constants and state type of the interrupt controller and wake-up block
package icwr_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int ADDR_W   = 8;   // Register address width
  localparam int DATA_W   = 16;  // Register data width
  localparam int NUM_SRC  = 48;  // Sources in three flag registers
  localparam int NUM_EXT  = 5;   // External request inputs
  localparam int NUM_PRIO = 12;  // Priority registers

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] CTRL1_OFS  = 8'h80;
  localparam logic [7:0] CTRL2_OFS  = 8'h82;
  localparam logic [7:0] STATUS_OFS = 8'hb0;
  localparam logic [7:0] MASK_OFS   = 8'hb2;
  localparam logic [2:0][7:0] FLAGS_OFS  = {8'h88, 8'h86, 8'h84};
  localparam logic [2:0][7:0] ENABLE_OFS = {8'h90, 8'h8e, 8'h8c};
  localparam logic [11:0][7:0] PRIO_OFS  = {8'haa, 8'ha8, 8'ha6, 8'ha4,
    8'ha2, 8'ha0, 8'h9e, 8'h9c, 8'h9a, 8'h98, 8'h96, 8'h94};

  // ****************************************
  // Field positions
  // ****************************************
  localparam int NEST_DIS_BIT  = 15;
  localparam int ACC_A_OVF_BIT = 10;
  localparam int ACC_B_OVF_BIT = 9;
  localparam int CAT_OVF_BIT   = 8;
  localparam int ARITH_BIT     = 4;
  localparam int ADDR_ERR_BIT  = 3;
  localparam int STACK_BIT     = 2;
  localparam int OSC_BIT       = 1;
  localparam int ALT_VEC_BIT   = 15;
  localparam int PRIO_W        = 3;
  localparam int PRIO_STRIDE   = 4;
  localparam logic [4:0][5:0] EXT_POS = {6'd37, 6'd36, 6'd23, 6'd16, 6'd0};
  localparam int ST_TRAP = 0;  // Trap flag raised
  localparam int ST_REQ  = 1;  // New request forwarded
  localparam int ST_WAKE = 2;  // Core woken

  // ****************************************
  // Implemented bits and reset values
  // ****************************************
  localparam logic [15:0]  CTRL1_MASK  = 16'h871e;
  localparam logic [15:0]  CTRL2_MASK  = 16'h801f;
  localparam logic [2:0]   STATUS_MSK  = 3'h7;
  localparam logic [47:0]  SRC_MASK    = {16'h1dff, 16'hffff, 16'hffff};
  localparam logic [191:0] PRIO_MASK   = {16'h7007, 16'h7707, {10{16'h7777}}};
  localparam logic [191:0] PRIO_RESET  = {16'h2000, 16'h4404, {10{16'h4444}}};

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ICWR_ACTIVE = 2'b01,
    ICWR_ASLEEP = 2'b10
  } icwr_pwr_t;

  typedef struct packed {
    logic [15:0]  ctrl1;
    logic [15:0]  ctrl2;
    logic [47:0]  flags;
    logic [47:0]  enables;
    logic [191:0] prio;
    logic [2:0]   status;
    logic [2:0]   mask;
    logic [4:0]   extPrev;
    icwr_pwr_t    pwr;
    logic         irqReq;
    logic [2:0]   irqPrio;
    logic [5:0]   irqSrc;
    logic         wake;
    logic         irqLine;
    logic [15:0]  rdData;
  } icwr_state_t;

  localparam icwr_state_t ICWR_RESET = '{
    ctrl1: 16'h0000, ctrl2: 16'h0000, flags: 48'h0, enables: 48'h0,
    prio: PRIO_RESET, status: 3'h0, mask: 3'h0, extPrev: 5'h00,
    pwr: ICWR_ACTIVE, irqReq: 1'b0, irqPrio: 3'h0, irqSrc: 6'h00,
    wake: 1'b0, irqLine: 1'b0, rdData: 16'h0000};

endpackage : icwr_pkg

// ### rtl/icwr_ctrl.sv
// Interrupt controller register map, request selection and wake-up
//
// What this block does
// - Interrupt wakes core from Sleep
// - Qualified request forwarded, core wakes same step
// - Trap flags at bits 4..1, reset clear
// - Overflow trap enables 10..8, nesting disable 15
// - Alternate vector bit 15, edge polarities 4..0
// - Flag and enable per source, reset zero
// - Four 3-bit priority fields, reset to four
// - Last two priority registers reset as printed
// - Two-line serial programming inputs unused, data line never driven
// - Forward only flagged, enabled, above core level
// - Alternate select redirects all vector fetches
// - External inputs edge sensitive, polarity selectable
`timescale 1ns/1ps

module icwr_ctrl
  import icwr_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic [icwr_pkg::ADDR_W-1:0] addr,
  input  wire logic [icwr_pkg::DATA_W-1:0] wrData,
  input  wire logic                       wrStrobe,
  input  wire logic                       rdStrobe,
  output logic      [icwr_pkg::DATA_W-1:0] rdData,
  input  wire logic [icwr_pkg::NUM_SRC-1:0] periphReq,
  input  wire logic                       trapArith,
  input  wire logic                       trapAddr,
  input  wire logic                       trapStack,
  input  wire logic                       trapOsc,
  input  wire logic [icwr_pkg::NUM_EXT-1:0] extIrqInputs,
  input  wire logic [3:0]                 cpuPriorityLevel,
  input  wire logic                       sleepEnter,
  output logic                            irqRequest,
  output logic      [2:0]                 irqPriority,
  output logic      [5:0]                 irqSource,
  output logic                            wakeUp,
  output logic                            altVectorSelect,
  output logic                            nestingDisable,
  output logic                            accAOverflowTrapEn,
  output logic                            accBOverflowTrapEn,
  output logic                            catastrophicOverflowTrapEn,
  output logic                            irqOut,
  input  wire logic                       progSerialClock,
  input  wire logic                       progSerialDataIn,
  output logic                            progSerialDataOut,
  output logic                            progSerialDataOe,
  input  wire logic                       masterClearPinN
);
  import icwr_pkg::*;

  // ****************************************
  // State
  // ****************************************
  icwr_state_t st;              // All registered state
  icwr_state_t nx;              // Next value of the state
  logic [NUM_EXT-1:0] extEdge;  // Active edge seen this cycle
  logic [47:0] setFlag;         // Hardware flag sets
  logic [15:0] rdVal;           // Read mux result
  logic        found;           // A request qualifies
  logic [2:0]  bestPrio;        // Highest qualifying priority
  logic [5:0]  bestSrc;         // Its source number

  // Priority field of one source
  function automatic logic [2:0] prioOf(input logic [191:0] p, input int n);
    prioOf = p[n*PRIO_STRIDE +: PRIO_W];
  endfunction : prioOf

  // Flag or enable register of one source bank, decoded by offset
  function automatic logic hitBank(input logic [7:0] a, input logic [7:0] ofs);
    hitBank = (a == ofs);
  endfunction : hitBank

  // ****************************************
  // External edge detection
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++) begin : gExt
      assign extEdge[g] = st.ctrl2[g] ? (st.extPrev[g] & ~extIrqInputs[g])
                                      : (~st.extPrev[g] & extIrqInputs[g]);
    end
  endgenerate

  // ****************************************
  // Request selection
  // ****************************************
  // Scans every source, keeps the highest priority above core level
  always_comb begin
    found    = 1'b0;
    bestPrio = 3'h0;
    bestSrc  = 6'h00;
    for (int n = 0; n < NUM_SRC; n++) begin
      if (st.flags[n] && st.enables[n] && ({1'b0, prioOf(st.prio, n)} > cpuPriorityLevel)
          && (!found || prioOf(st.prio, n) > bestPrio)) begin
        found    = 1'b1;
        bestPrio = prioOf(st.prio, n);
        bestSrc  = n[5:0];
      end
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  // Unimplemented bits are masked off before leaving the block
  always_comb begin
    rdVal = 16'h0000;
    if (addr == CTRL1_OFS) begin
      rdVal = st.ctrl1;
    end else if (addr == CTRL2_OFS) begin
      rdVal = st.ctrl2;
    end else if (addr == STATUS_OFS) begin
      rdVal = {13'h0000, st.status};
    end else if (addr == MASK_OFS) begin
      rdVal = {13'h0000, st.mask};
    end
    for (int k = 0; k < 3; k++) begin
      if (hitBank(addr, FLAGS_OFS[k])) begin
        rdVal = st.flags[k*16 +: 16];
      end
      if (hitBank(addr, ENABLE_OFS[k])) begin
        rdVal = st.enables[k*16 +: 16];
      end
    end
    for (int k = 0; k < NUM_PRIO; k++) begin
      if (addr == PRIO_OFS[k]) begin
        rdVal = st.prio[k*16 +: 16];
      end
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nx         = st;
    nx.extPrev = extIrqInputs;
    nx.wake    = 1'b0;
    setFlag    = periphReq;
    for (int i = 0; i < NUM_EXT; i++) begin
      if (extEdge[i]) begin
        setFlag[EXT_POS[i]] = 1'b1;
      end
    end
    // Software writes, unimplemented bits dropped
    if (wrStrobe) begin
      if (addr == CTRL1_OFS) begin
        nx.ctrl1 = wrData & CTRL1_MASK;
      end
      if (addr == CTRL2_OFS) begin
        nx.ctrl2 = wrData & CTRL2_MASK;
      end
      if (addr == MASK_OFS) begin
        nx.mask = wrData[2:0] & STATUS_MSK;
      end
      for (int k = 0; k < 3; k++) begin
        if (hitBank(addr, FLAGS_OFS[k])) begin
          nx.flags[k*16 +: 16] = wrData & SRC_MASK[k*16 +: 16];
        end
        if (hitBank(addr, ENABLE_OFS[k])) begin
          nx.enables[k*16 +: 16] = wrData & SRC_MASK[k*16 +: 16];
        end
      end
      for (int k = 0; k < NUM_PRIO; k++) begin
        if (addr == PRIO_OFS[k]) begin
          nx.prio[k*16 +: 16] = wrData & PRIO_MASK[k*16 +: 16];
        end
      end
    end
    // Hardware sets win over a clearing write
    nx.flags = nx.flags | (setFlag & SRC_MASK);
    // trap flags set by their events
    nx.ctrl1[ARITH_BIT]    = nx.ctrl1[ARITH_BIT] | trapArith;
    nx.ctrl1[ADDR_ERR_BIT] = nx.ctrl1[ADDR_ERR_BIT] | trapAddr;
    nx.ctrl1[STACK_BIT]    = nx.ctrl1[STACK_BIT] | trapStack;
    nx.ctrl1[OSC_BIT]      = nx.ctrl1[OSC_BIT] | trapOsc;
    // Request outputs follow the selection
    // forward the qualified request
    nx.irqReq  = found;
    nx.irqPrio = bestPrio;
    nx.irqSrc  = bestSrc;
    // Low-power tracking
    case (st.pwr)
      ICWR_ACTIVE: begin
        if (sleepEnter) begin
          nx.pwr = ICWR_ASLEEP;
        end
      end
      ICWR_ASLEEP: begin
        if (found) begin
          nx.pwr  = ICWR_ACTIVE;
          nx.wake = 1'b1;
        end
      end
      default: begin
        nx.pwr = ICWR_ACTIVE;
      end
    endcase
    // Status: a read clears, a new event wins
    if (rdStrobe && addr == STATUS_OFS) begin
      nx.status = 3'h0;
    end
    nx.status[ST_TRAP] = nx.status[ST_TRAP] | trapArith | trapAddr | trapStack | trapOsc;
    nx.status[ST_REQ]  = nx.status[ST_REQ] | (found & ~st.irqReq);
    nx.status[ST_WAKE] = nx.status[ST_WAKE] | nx.wake;
    nx.irqLine = |(nx.status & nx.mask);
    // Read data stands one cycle only
    nx.rdData = rdStrobe ? rdVal : 16'h0000;
  end

  // ****************************************
  // State register
  // ****************************************
  // whole map loads its reset image
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= ICWR_RESET;
    end else begin
      st <= nx;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdData          = st.rdData;
  assign irqRequest      = st.irqReq;
  assign irqPriority     = st.irqPrio;
  assign irqSource       = st.irqSrc;
  assign wakeUp          = st.wake;
  assign irqOut          = st.irqLine;
  // vector table choice to the core
  assign altVectorSelect = st.ctrl2[ALT_VEC_BIT];
  assign nestingDisable  = st.ctrl1[NEST_DIS_BIT];
  assign accAOverflowTrapEn         = st.ctrl1[ACC_A_OVF_BIT];
  assign accBOverflowTrapEn         = st.ctrl1[ACC_B_OVF_BIT];
  assign catastrophicOverflowTrapEn = st.ctrl1[CAT_OVF_BIT];
  assign progSerialDataOut = 1'b0;
  assign progSerialDataOe  = 1'b0;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cbSys @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence sAsleepReq;
    st.pwr == ICWR_ASLEEP && found;
  endsequence

  sequence sWoken;
    wakeUp && irqRequest && st.pwr == ICWR_ACTIVE;
  endsequence

  a_wake_on_req: assert property (sAsleepReq |=> sWoken)
    else $error("core not woken by request");

  a_req_level: assert property (irqRequest |-> {1'b0, irqPriority} > $past(cpuPriorityLevel))
    else $error("request at or below core level");

  a_req_fwd: assert property (periphReq[1] && !wrStrobe ##1 st.enables[1] && prioOf(st.prio, 1) == 3'h7
    && cpuPriorityLevel < 4'h7 |=> irqRequest && irqPriority == 3'h7)
    else $error("qualified request not forwarded");

  a_trap_flag: assert property (trapStack |=> st.ctrl1[STACK_BIT] ##1 st.ctrl1[STACK_BIT] || $past(wrStrobe))
    else $error("stack trap flag not held");

  a_ovf_enable: assert property (wrStrobe && addr == CTRL1_OFS |=>
    accAOverflowTrapEn == $past(wrData[ACC_A_OVF_BIT]) && nestingDisable == $past(wrData[NEST_DIS_BIT]))
    else $error("trap enable write lost");

  a_alt_vector: assert property (wrStrobe && addr == CTRL2_OFS |=> altVectorSelect == $past(wrData[15]))
    else $error("alternate select not taken");

  a_ext_edge: assert property (!st.ctrl2[0] && !st.extPrev[0] && extIrqInputs[0] |=> st.flags[0])
    else $error("rising edge lost on input 0");

  a_prio_reset: assert property ($fell(rst) |-> st.prio == PRIO_RESET && st.flags == 48'h0)
    else $error("priority reset image wrong");

  a_last_prio: assert property ($fell(rst) |-> st.prio[191:160] == 32'h20004404)
    else $error("last priority registers reset wrong");

  a_unimpl_zero: assert property (rdStrobe && addr == FLAGS_OFS[2] |=> rdData[15:13] == 3'h0 && !rdData[9])
    else $error("unimplemented bits read nonzero");

  a_flag_set: assert property (periphReq[20] |=> st.flags[20])
    else $error("flag set lost against write");

  a_prog_quiet: assert property (!progSerialDataOe [*2])
    else $error("serial data line driven");

endmodule : icwr_ctrl

// ### sim/icwr_core_model.sv
// Behavioural model of the processor core facing the interrupt controller
`timescale 1ns/1ps

module icwr_core_model (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       irqRequest,
  input  wire logic       wakeUp,
  input  wire logic [3:0] levelCmd,
  input  wire logic       sleepCmd,
  output logic      [3:0] cpuPriorityLevel,
  output logic            sleepEnter,
  output logic            asleep
);

  // ****************************************
  // Core state
  // ****************************************
  // Priority follows the bench one cycle late, as a real core updating its status would
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cpuPriorityLevel <= 4'h0;
      sleepEnter       <= 1'b0;
      asleep           <= 1'b0;
    end else begin
      cpuPriorityLevel <= levelCmd;
      sleepEnter       <= sleepCmd;
      // Leave low power only when a request arrives with the wake pulse
      if (wakeUp && irqRequest) begin
        asleep <= 1'b0;
      end else if (sleepEnter) begin
        asleep <= 1'b1;
      end
    end
  end

endmodule : icwr_core_model

// ### sim/icwr_ctrl_tb.sv
// Self-checking bench of the interrupt controller and wake-up block
`timescale 1ns/1ps

module icwr_ctrl_tb;
  import icwr_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic        clk_sys      = 1'b0;     // System clock
  logic        rst          = 1'b1;     // Synchronous reset
  logic [7:0]  addr         = 8'h00;    // Register address
  logic [15:0] wrData       = 16'h0000; // Write data
  logic        wrStrobe     = 1'b0;     // Write strobe
  logic        rdStrobe     = 1'b0;     // Read strobe
  logic [47:0] periphReq    = 48'h0;    // Peripheral events
  logic [3:0]  trapVec      = 4'h0;     // Osc, stack, addr, arith traps
  logic [4:0]  extIrqInputs = 5'h00;    // External request pins
  logic [3:0]  levelCmd     = 4'h0;     // Wanted core priority
  logic        sleepCmd     = 1'b0;     // Ask core to sleep
  logic [15:0] rdData;
  logic [3:0]  cpuPriorityLevel;
  logic [2:0]  irqPriority;
  logic [5:0]  irqSource;
  logic [2:0]  ovfEn;                   // Overflow trap enables A, B, catastrophic
  logic        sleepEnter, asleep, irqRequest, wakeUp, altVectorSelect, nestingDisable, irqOut, progDataOe;
  int          badCount     = 0;        // Mismatches
  int          testsRun     = 0;        // Comparisons

  // Clock at 50 MHz
  always #10 clk_sys = ~clk_sys;

  // ****************************************
  // Instances
  // ****************************************
  icwr_ctrl icwr_ctrl_i (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .periphReq(periphReq), .trapArith(trapVec[3]),
    .trapAddr(trapVec[2]), .trapStack(trapVec[1]), .trapOsc(trapVec[0]), .extIrqInputs(extIrqInputs),
    .cpuPriorityLevel(cpuPriorityLevel), .sleepEnter(sleepEnter), .irqRequest(irqRequest),
    .irqPriority(irqPriority), .irqSource(irqSource), .wakeUp(wakeUp), .altVectorSelect(altVectorSelect),
    .nestingDisable(nestingDisable), .accAOverflowTrapEn(ovfEn[2]), .accBOverflowTrapEn(ovfEn[1]),
    .catastrophicOverflowTrapEn(ovfEn[0]), .irqOut(irqOut), .progSerialClock(1'b0),
    .progSerialDataIn(1'b1), .progSerialDataOut(), .progSerialDataOe(progDataOe), .masterClearPinN(1'b1));

  icwr_core_model icwr_core_model_i (.clk_sys(clk_sys), .rst(rst), .irqRequest(irqRequest), .wakeUp(wakeUp),
    .levelCmd(levelCmd), .sleepCmd(sleepCmd), .cpuPriorityLevel(cpuPriorityLevel), .sleepEnter(sleepEnter),
    .asleep(asleep));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic conclude;
    $display("checks %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // Compare a register value
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected value at %0t: %h, wanted %h", $time, got, exp);
    end
  endtask : chk16

  // Compare a single output flag
  task automatic chk1(input logic got, input logic exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected flag at %0t: %b, wanted %b", $time, got, exp);
    end
  endtask : chk1

  // Wait n edges, then let updates settle
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wrStrobe <= 1'b1;
    addr     <= a;
    wrData   <= d;
    @(posedge clk_sys);
    wrStrobe <= 1'b0;
  endtask : wr

  // One-cycle register read, data judged in the following cycle
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    rdStrobe <= 1'b1;
    addr     <= a;
    @(posedge clk_sys);
    rdStrobe <= 1'b0;
    #1 chk16(rdData, exp);
  endtask : rd

  // One-cycle event on a peripheral source, returns when the request is due
  task automatic pulse(input int n);
    @(posedge clk_sys);
    periphReq <= 48'h1 << n;
    @(posedge clk_sys);
    periphReq <= 48'h0;
    cyc(1);
  endtask : pulse

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rd(CTRL1_OFS, 16'h0000);
    rd(CTRL2_OFS, 16'h0000);
    rd(FLAGS_OFS[2], 16'h0000);
    rd(ENABLE_OFS[1], 16'h0000);
    rd(PRIO_OFS[0], 16'h4444);
    rd(PRIO_OFS[10], 16'h4404);
    rd(PRIO_OFS[11], 16'h2000);
    chk1(progDataOe, 1'b0);
  endtask : t_reset

  task automatic t_unimpl;
    wr(CTRL1_OFS, 16'hffff);
    rd(CTRL1_OFS, 16'h871e);
    chk1(nestingDisable, 1'b1);
    chk16({13'h0, ovfEn}, 16'h0007);
    wr(CTRL2_OFS, 16'hffff);
    rd(CTRL2_OFS, 16'h801f);
    chk1(altVectorSelect, 1'b1);
    wr(PRIO_OFS[10], 16'hffff);
    rd(PRIO_OFS[10], 16'h7707);
    wr(PRIO_OFS[11], 16'hffff);
    rd(PRIO_OFS[11], 16'h7007);
    wr(8'hfe, 16'hffff);
    rd(8'hfe, 16'h0000);
    wr(CTRL1_OFS, 16'h0000);
    wr(CTRL2_OFS, 16'h0000);
    wr(PRIO_OFS[10], 16'h4404);
    wr(PRIO_OFS[11], 16'h2000);
    cyc(1);
    chk1(altVectorSelect, 1'b0);
  endtask : t_unimpl

  task automatic t_traps;
    wr(MASK_OFS, 16'h0001);
    // Each trap alone, so swapped positions show
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      trapVec <= 4'h1 << i;
      @(posedge clk_sys);
      trapVec <= 4'h0;
      rd(CTRL1_OFS, 16'h0002 << i);
      wr(CTRL1_OFS, 16'h0000);
    end
    chk1(irqOut, 1'b1);
    rd(STATUS_OFS, 16'h0001);
    cyc(2);
    chk1(irqOut, 1'b0);
    wr(MASK_OFS, 16'h0000);
  endtask : t_traps

  task automatic t_request;
    @(posedge clk_sys) levelCmd <= 4'h3;
    pulse(5);
    chk1(irqRequest, 1'b0);
    wr(ENABLE_OFS[0], 16'h0020);
    cyc(2);
    chk1(irqRequest, 1'b1);
    chk16({10'h0, irqSource}, 16'h0005);
    chk16({13'h0, irqPriority}, 16'h0004);
    chk1(wakeUp, 1'b0);
    @(posedge clk_sys) levelCmd <= 4'h4;
    cyc(3);
    chk1(irqRequest, 1'b0);
    @(posedge clk_sys) levelCmd <= 4'h3;
    wr(PRIO_OFS[1], 16'h4644);
    wr(ENABLE_OFS[0], 16'h0060);
    pulse(6);
    chk16({10'h0, irqSource}, 16'h0006);
    chk16({13'h0, irqPriority}, 16'h0006);
    wr(FLAGS_OFS[0], 16'h0000);
    wr(PRIO_OFS[1], 16'h4444);
    cyc(2);
    chk1(irqRequest, 1'b0);
    rd(STATUS_OFS, 16'h0002);
    // Top priority on source 1 reaches the core
    wr(PRIO_OFS[0], 16'h4474);
    wr(ENABLE_OFS[0], 16'h0002);
    pulse(1);
    chk16({10'h0, irqSource}, 16'h0001);
    chk16({13'h0, irqPriority}, 16'h0007);
    pulse(20);
    rd(FLAGS_OFS[1], 16'h0010);
    wr(FLAGS_OFS[0], 16'h0000);
    wr(FLAGS_OFS[1], 16'h0000);
    wr(PRIO_OFS[0], 16'h4444);
  endtask : t_request

  task automatic t_wake;
    wr(ENABLE_OFS[0], 16'h0020);
    wr(MASK_OFS, 16'h0004);
    @(posedge clk_sys) sleepCmd <= 1'b1;
    @(posedge clk_sys) sleepCmd <= 1'b0;
    cyc(3);
    chk1(asleep, 1'b1);
    pulse(5);
    chk1(wakeUp, 1'b1);
    chk1(irqRequest, 1'b1);
    cyc(1);
    chk1(wakeUp, 1'b0);
    chk1(asleep, 1'b0);
    chk1(irqOut, 1'b1);
    rd(STATUS_OFS, 16'h0006);
    wr(FLAGS_OFS[0], 16'h0000);
    wr(ENABLE_OFS[0], 16'h0000);
  endtask : t_wake

  task automatic t_ext;
    @(posedge clk_sys) extIrqInputs <= 5'h01;
    cyc(3);
    rd(FLAGS_OFS[0], 16'h0001);
    wr(FLAGS_OFS[0], 16'h0000);
    @(posedge clk_sys) extIrqInputs <= 5'h00;
    cyc(3);
    rd(FLAGS_OFS[0], 16'h0000);
    wr(CTRL2_OFS, 16'h0002);
    @(posedge clk_sys) extIrqInputs <= 5'h02;
    cyc(3);
    rd(FLAGS_OFS[1], 16'h0000);
    @(posedge clk_sys) extIrqInputs <= 5'h00;
    cyc(3);
    rd(FLAGS_OFS[1], 16'h0001);
  endtask : t_ext

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_unimpl();
    t_traps();
    t_request();
    t_wake();
    t_ext();
    conclude();
  end

  // Cut a hang short after far more than the run needs
  initial begin
    #200000;
    badCount++;
    $display("unexpected hang at %0t", $time);
    conclude();
  end

endmodule : icwr_ctrl_tb
